// ===== hdl/cmd_key.sv
`timescale 1ns/1ps
module cmd_key #(
	parameter int DEB_CYC = cmd_pkg::DEBOUNCE_CYC,
	parameter int LONG_CYC = cmd_pkg::LONG_PRESS_CYC
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// raw key pin, low while pressed
	input wire logic i_key_n,
	// key events
	output cmd_pkg::cmd_keyev_t o_ev
);
	logic sync1_reg, sync2_reg, stable_reg, long_done_reg;
	logic [31:0] deb_reg, hold_reg;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
		end else begin
			sync1_reg <= ~i_key_n;
			sync2_reg <= sync1_reg;
		end
	end

	// level must hold for the whole window before it counts
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			deb_reg <= 32'h0;
			stable_reg <= 1'b0;
		end else if (sync2_reg == stable_reg) begin
			deb_reg <= 32'h0;
		end else if (deb_reg == 32'(DEB_CYC - 1)) begin
			deb_reg <= 32'h0;
			stable_reg <= sync2_reg;
		end else begin
			deb_reg <= deb_reg + 32'h1;
		end
	end

	// short press reported on release, long press while held
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			hold_reg <= 32'h0;
			long_done_reg <= 1'b0;
			o_ev <= '0;
		end else begin
			o_ev.press <= (deb_reg == 32'(DEB_CYC - 1)) & sync2_reg;
			o_ev.short_rel <= (deb_reg == 32'(DEB_CYC - 1)) & ~sync2_reg
				& ~long_done_reg;
			o_ev.long_hold <= stable_reg & ~long_done_reg
				& (hold_reg == 32'(LONG_CYC - 1));
			if (!stable_reg) begin
				hold_reg <= 32'h0;
				long_done_reg <= 1'b0;
			end else if (hold_reg == 32'(LONG_CYC - 1)) begin
				long_done_reg <= 1'b1;
			end else begin
				hold_reg <= hold_reg + 32'h1;
			end
		end
	end
endmodule : cmd_key

// ===== hdl/cmd_menu_ctrl.sv
`timescale 1ns/1ps
module cmd_menu_ctrl #(
	parameter int DEB_CYC = cmd_pkg::DEBOUNCE_CYC,
	parameter int LONG_CYC = cmd_pkg::LONG_PRESS_CYC,
	parameter int IDLE_CYC = cmd_pkg::CAL_IDLE_CYC,
	parameter int ALT_CYC = cmd_pkg::ALT_CYC
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// key pins, low while pressed: fwd, back, plus, minus
	input wire logic [3:0] i_key_n,
	// temperature sensor reading
	input wire logic [9:0] i_temp_mv,
	input wire logic i_temp_present,
	// radio receiver and decoder
	input wire logic i_radio_pin,
	input wire logic i_syncing,
	input wire logic i_synced,
	input wire cmd_pkg::cmd_sync_t i_sync_stage,
	input wire logic [15:0] i_time_bcd,
	input wire logic [15:0] i_date_bcd,
	input wire logic [4:0] i_norm_bright,
	// register port
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// display and indicators
	output cmd_pkg::cmd_disp_t o_disp,
	output logic [4:0] o_bright,
	output logic o_auto_bright_en,
	output logic o_alarm_tmp,
	output logic o_rx_led
);
	cmd_pkg::cmd_keyev_t [3:0] ev;
	cmd_pkg::cmd_menu_t item_reg;
	cmd_pkg::cmd_dmode_t dmode_reg;
	cmd_pkg::cmd_cal_t cal_reg;
	cmd_pkg::cmd_disp_t disp_next;
	logic in_sub_reg, temp_en_reg, flash_reg, rx_led_en_reg;
	logic radio1_reg, radio2_reg;
	logic [3:0] sub_reg;
	logic [4:0] rx_bright_reg;
	logic [1:0] phase_reg;
	logic [31:0] alt_reg, idle_reg;
	logic signed [12:0] ofs_reg, edit_reg, tenths;
	logic signed [7:0] deg;
	logic fwd, back, plus, minus, plus_s, minus_s, plus_l, minus_l;
	logic has_sub, on_exit, temp_on, menu_keys_ok;

	////////////////////////////////////////////////////////////////
	genvar k;
	generate
		for (k = 0; k < cmd_pkg::NUM_KEYS; k++) begin : g_key
			cmd_key #(
				.DEB_CYC(DEB_CYC),
				.LONG_CYC(LONG_CYC)
			) u_key (
				.i_clk(i_clk),
				.i_rst(i_rst),
				.i_key_n(i_key_n[k]),
				.o_ev(ev[k])
			);
		end
	endgenerate

	cmd_temp u_temp (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_mv(i_temp_mv),
		.i_ofs(ofs_reg),
		.o_tenths(tenths),
		.o_deg(deg)
	);

	assign fwd = ev[cmd_pkg::KEY_FWD].press;
	assign back = ev[cmd_pkg::KEY_BACK].press;
	assign plus = ev[cmd_pkg::KEY_PLUS].press;
	assign minus = ev[cmd_pkg::KEY_MINUS].press;
	assign plus_s = ev[cmd_pkg::KEY_PLUS].short_rel;
	assign minus_s = ev[cmd_pkg::KEY_MINUS].short_rel;
	assign plus_l = ev[cmd_pkg::KEY_PLUS].long_hold;
	assign minus_l = ev[cmd_pkg::KEY_MINUS].long_hold;
	assign has_sub = (cmd_pkg::sub_exit(item_reg) != 4'h0);
	assign on_exit = in_sub_reg & (sub_reg == cmd_pkg::sub_exit(item_reg));
	assign temp_on = temp_en_reg & i_temp_present;
	// menu keys wait while a calibration edit is open
	assign menu_keys_ok = (cal_reg == cmd_pkg::CAL_IDLE);

	////////////////////////////////////////////////////////////////
	// menu position
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			item_reg <= cmd_pkg::MI_NORMAL;
			sub_reg <= 4'h0;
			in_sub_reg <= 1'b0;
		end else if (menu_keys_ok) begin
			if (fwd && in_sub_reg) begin
				sub_reg <= on_exit ? 4'h0 : sub_reg + 4'h1;
			end else if (fwd) begin
				item_reg <= (item_reg == cmd_pkg::MI_FW) ?
					cmd_pkg::MI_NORMAL :
					cmd_pkg::cmd_menu_t'(item_reg + 4'h1);
			end else if (back && in_sub_reg) begin
				sub_reg <= (sub_reg == 4'h0) ?
					cmd_pkg::sub_exit(item_reg) : sub_reg - 4'h1;
			end else if (back) begin
				item_reg <= (item_reg == cmd_pkg::MI_NORMAL) ?
					cmd_pkg::MI_FW :
					cmd_pkg::cmd_menu_t'(item_reg - 4'h1);
			end else if (plus && on_exit) begin
				in_sub_reg <= 1'b0;
			end else if (plus && has_sub && !in_sub_reg) begin
				in_sub_reg <= 1'b1;
				sub_reg <= 4'h0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// settings; they live here and survive menu exit
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			dmode_reg <= cmd_pkg::DM_TIME;
			temp_en_reg <= 1'b0;
		end else if (menu_keys_ok && item_reg == cmd_pkg::MI_DISP) begin
			if (plus) begin
				dmode_reg <= cmd_pkg::cmd_dmode_t'(dmode_reg + 2'h1);
			end else if (minus) begin
				dmode_reg <= cmd_pkg::cmd_dmode_t'(dmode_reg - 2'h1);
			end
		end else if (menu_keys_ok && item_reg == cmd_pkg::MI_TEMP) begin
			if (plus_s) begin
				temp_en_reg <= 1'b1;
			end else if (minus_s) begin
				temp_en_reg <= 1'b0;
			end
		end
	end

	// normal-mode plus and minus
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_alarm_tmp <= 1'b0;
			flash_reg <= 1'b0;
		end else if (item_reg == cmd_pkg::MI_NORMAL) begin
			if (plus) begin
				o_alarm_tmp <= ~o_alarm_tmp;
			end
			if (minus) begin
				flash_reg <= ~flash_reg;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// calibration: edit in tenths, applied after the keys go idle
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cal_reg <= cmd_pkg::CAL_IDLE;
			ofs_reg <= 13'sh0000;
			edit_reg <= 13'sh0000;
			idle_reg <= 32'h0;
		end else begin
			case (cal_reg)
				cmd_pkg::CAL_IDLE: begin
					idle_reg <= 32'h0;
					if (item_reg == cmd_pkg::MI_TEMP && plus_l) begin
						cal_reg <= cmd_pkg::CAL_REF;
						edit_reg <= (tenths > cmd_pkg::CAL_MAX) ?
							cmd_pkg::CAL_MAX : tenths;
					end else if (item_reg == cmd_pkg::MI_TEMP && minus_l) begin
						cal_reg <= cmd_pkg::CAL_OFS;
						edit_reg <= ofs_reg;
					end
				end
				cmd_pkg::CAL_REF, cmd_pkg::CAL_OFS: begin
					if (plus || minus) begin
						idle_reg <= 32'h0;
					end else begin
						idle_reg <= idle_reg + 32'h1;
					end
					if (plus && edit_reg < cmd_pkg::CAL_MAX) begin
						edit_reg <= edit_reg + cmd_pkg::CAL_STEP;
					end else if (minus && edit_reg > cmd_pkg::CAL_MIN) begin
						edit_reg <= edit_reg - cmd_pkg::CAL_STEP;
					end
					if (idle_reg == 32'(IDLE_CYC - 1)) begin
						cal_reg <= cmd_pkg::CAL_IDLE;
						// reference mode: offset = wanted minus raw
						ofs_reg <= (cal_reg == cmd_pkg::CAL_REF) ?
							edit_reg - $signed({3'b000, i_temp_mv}) :
							edit_reg;
					end
				end
				default: cal_reg <= cmd_pkg::CAL_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// alternation timer; phase count depends on mode and temperature
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			alt_reg <= 32'h0;
			phase_reg <= 2'h0;
		end else if (alt_reg == 32'(ALT_CYC - 1)) begin
			alt_reg <= 32'h0;
			if (phase_reg >= {1'b0, dmode_reg == cmd_pkg::DM_TIME_DATE}
				+ {1'b0, temp_on}) begin
				phase_reg <= 2'h0;
			end else begin
				phase_reg <= phase_reg + 2'h1;
			end
		end else begin
			alt_reg <= alt_reg + 32'h1;
		end
	end

	////////////////////////////////////////////////////////////////
	function automatic logic [4:0] dig(input logic [3:0] v);
		dig = {1'b0, v};
	endfunction : dig

	function automatic cmd_pkg::cmd_disp_t show_bcd(input logic [15:0] b);
		show_bcd.sym = {dig(b[15:12]), dig(b[11:8]), dig(b[7:4]),
			dig(b[3:0])};
		show_bcd.dp = 4'h4;
	endfunction : show_bcd

	function automatic cmd_pkg::cmd_disp_t show_deg(input logic signed [7:0] d);
		logic [7:0] m;
		m = (d < 0) ? 8'(-d) : 8'(d);
		show_deg.sym = {(d < 0) ? cmd_pkg::SYM_DASH : cmd_pkg::SYM_BLANK,
			dig(4'(m / 8'h0A)), dig(4'(m % 8'h0A)), cmd_pkg::SYM_DEG};
		show_deg.dp = 4'h0;
	endfunction : show_deg

	// tenths shown with one decimal: s d d . d
	function automatic cmd_pkg::cmd_disp_t show_tenths(
		input logic signed [12:0] t);
		logic [12:0] m;
		m = (t < 0) ? 13'(-t) : 13'(t);
		show_tenths.sym = {(t < 0) ? cmd_pkg::SYM_DASH : cmd_pkg::SYM_BLANK,
			dig(4'(m / 13'h0064)), dig(4'((m / 13'h000A) % 13'h000A)),
			dig(4'(m % 13'h000A))};
		show_tenths.dp = 4'h2;
	endfunction : show_tenths

	// display content, one register stage to the pins
	always_comb begin
		disp_next.sym = {4{cmd_pkg::SYM_DASH}};
		disp_next.dp = 4'h0;
		if (cal_reg != cmd_pkg::CAL_IDLE) begin
			disp_next = show_tenths(edit_reg);
		end else if (item_reg != cmd_pkg::MI_NORMAL) begin
			disp_next.sym[3] = cmd_pkg::SYM_DASH;
			disp_next.sym[2] = dig(item_reg);
			disp_next.sym[1] = in_sub_reg ? dig(sub_reg) : cmd_pkg::SYM_BLANK;
			disp_next.sym[0] = on_exit ? cmd_pkg::SYM_E : cmd_pkg::SYM_BLANK;
			if (item_reg == cmd_pkg::MI_DISP) begin
				disp_next.sym[0] = dig({2'b00, dmode_reg});
			end else if (item_reg == cmd_pkg::MI_TEMP) begin
				disp_next.sym[0] = dig({3'b000, temp_en_reg});
			end
		end else if (i_syncing && rx_bright_reg == 5'h00) begin
			disp_next.sym = {4{cmd_pkg::SYM_BLANK}};
			disp_next.dp = 4'h1;
		end else if (i_syncing) begin
			case (i_sync_stage)
				cmd_pkg::SY_NOSIG: disp_next.sym = {cmd_pkg::SYM_N,
					cmd_pkg::SYM_O, cmd_pkg::SYM_S, cmd_pkg::SYM_BLANK};
				cmd_pkg::SY_SEARCH: disp_next.sym = {cmd_pkg::SYM_S,
					cmd_pkg::SYM_E, cmd_pkg::SYM_R, cmd_pkg::SYM_C};
				cmd_pkg::SY_READ: disp_next.sym = {cmd_pkg::SYM_R,
					cmd_pkg::SYM_D, dig(4'h6), dig(4'h0)};
				default: disp_next.sym = {4{cmd_pkg::SYM_DASH}};
			endcase
		end else if (dmode_reg == cmd_pkg::DM_OFF) begin
			if (temp_on) begin
				disp_next = show_deg(deg);
			end
		end else if (phase_reg == 2'h0) begin
			disp_next = show_bcd((dmode_reg == cmd_pkg::DM_DATE) ?
				i_date_bcd : i_time_bcd);
		end else if (phase_reg == 2'h1 &&
			dmode_reg == cmd_pkg::DM_TIME_DATE) begin
			disp_next = show_bcd(i_date_bcd);
		end else if (temp_on) begin
			disp_next = show_deg(deg);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_disp <= '0;
			o_bright <= 5'h00;
			o_auto_bright_en <= 1'b1;
		end else begin
			o_disp <= disp_next;
			o_auto_bright_en <= ~flash_reg;
			if (flash_reg) begin
				o_bright <= cmd_pkg::BRIGHT_FULL;
			end else if (i_syncing) begin
				o_bright <= rx_bright_reg;
			end else begin
				o_bright <= i_norm_bright;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// receive indicator; pin is asynchronous
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			radio1_reg <= 1'b0;
			radio2_reg <= 1'b0;
			o_rx_led <= 1'b0;
		end else begin
			radio1_reg <= i_radio_pin;
			radio2_reg <= radio1_reg;
			o_rx_led <= rx_led_en_reg & ~i_synced & radio2_reg;
		end
	end

	////////////////////////////////////////////////////////////////
	// register port; read data valid only in the cycle after the strobe
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rx_led_en_reg <= cmd_pkg::CFG_RXLED_RST;
			rx_bright_reg <= cmd_pkg::CFG_RXBR_RST;
		end else if (i_wr && i_addr == cmd_pkg::REG_CFG) begin
			rx_led_en_reg <= i_wdata[cmd_pkg::CFG_RXLED_BIT];
			rx_bright_reg <= i_wdata[cmd_pkg::CFG_RXBR_LSB +: 5];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst || !i_rd) begin
			o_rdata <= 32'h0;
		end else begin
			case (i_addr)
				cmd_pkg::REG_CFG: o_rdata <= {19'h0, rx_bright_reg,
					7'h0, rx_led_en_reg};
				cmd_pkg::REG_STATUS: o_rdata <= {16'h0, cal_reg,
					flash_reg, o_alarm_tmp, temp_en_reg, dmode_reg,
					in_sub_reg, sub_reg, item_reg};
				cmd_pkg::REG_TEMP: o_rdata <= {3'h0, ofs_reg, 8'h0, deg};
				default: o_rdata <= 32'h0;
			endcase
		end
	end
endmodule : cmd_menu_ctrl

// ===== hdl/cmd_pkg.sv
package cmd_pkg;
	// timing, all derived from the 25 MHz system clock
	localparam int CLK_HZ = 25_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int DEBOUNCE_MS = 20;
	localparam int LONG_PRESS_MS = 1000;
	localparam int CAL_IDLE_MS = 2000;
	localparam int ALT_MS = 4000;
	localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
	localparam int LONG_PRESS_CYC = LONG_PRESS_MS * CYC_PER_MS;
	localparam int CAL_IDLE_CYC = CAL_IDLE_MS * CYC_PER_MS;
	localparam int ALT_CYC = ALT_MS * CYC_PER_MS;

	// key positions
	localparam int KEY_FWD = 0;
	localparam int KEY_BACK = 1;
	localparam int KEY_PLUS = 2;
	localparam int KEY_MINUS = 3;
	localparam int NUM_KEYS = 4;

	// brightness level 25 is 100 %
	localparam logic [4:0] BRIGHT_FULL = 5'h19;

	// temperature in tenths of a degree (1 mV of sensor = 0.1 C)
	localparam int TEMP_W = 13;
	localparam logic signed [12:0] CAL_MAX = 13'sh03E7;
	localparam logic signed [12:0] CAL_MIN = 13'sh1C19;
	localparam logic signed [12:0] CAL_STEP = 13'sh0001;
	localparam logic signed [12:0] ROUND_HALF = 13'sh0005;
	localparam logic signed [12:0] TENTHS = 13'sh000A;

	// display symbols
	localparam logic [4:0] SYM_BLANK = 5'h10;
	localparam logic [4:0] SYM_DASH = 5'h11;
	localparam logic [4:0] SYM_DEG = 5'h12;
	localparam logic [4:0] SYM_N = 5'h13;
	localparam logic [4:0] SYM_O = 5'h14;
	localparam logic [4:0] SYM_S = 5'h15;
	localparam logic [4:0] SYM_E = 5'h16;
	localparam logic [4:0] SYM_R = 5'h17;
	localparam logic [4:0] SYM_C = 5'h18;
	localparam logic [4:0] SYM_D = 5'h19;
	localparam logic [4:0] SYM_T = 5'h1A;

	// register map
	localparam logic [3:0] REG_CFG = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_TEMP = 4'h8;
	localparam int CFG_RXLED_BIT = 0;
	localparam int CFG_RXBR_LSB = 8;
	localparam logic CFG_RXLED_RST = 1'b1;
	localparam logic [4:0] CFG_RXBR_RST = 5'h0A;

	// last (exit) item of each submenu
	localparam logic [3:0] EXIT_ALARM = 4'h6;
	localparam logic [3:0] EXIT_BRIGHT = 4'hA;
	localparam logic [3:0] EXIT_RADIO = 4'h8;
	localparam logic [3:0] EXIT_CLOCK = 4'h8;

	typedef enum logic [3:0] {
		MI_NORMAL, MI_DISP, MI_TEMP, MI_ALARM, MI_BRIGHT,
		MI_RADIO, MI_CLOCK, MI_INFO, MI_CHIP, MI_FW
	} cmd_menu_t;

	typedef enum logic [1:0] {
		DM_OFF, DM_TIME, DM_DATE, DM_TIME_DATE
	} cmd_dmode_t;

	typedef enum logic [1:0] {SY_NOSIG, SY_SEARCH, SY_READ} cmd_sync_t;

	typedef enum logic [1:0] {CAL_IDLE, CAL_REF, CAL_OFS} cmd_cal_t;

	typedef struct packed {
		logic press;
		logic short_rel;
		logic long_hold;
	} cmd_keyev_t;

	typedef struct packed {
		logic [3:0][4:0] sym;
		logic [3:0] dp;
	} cmd_disp_t;

	function automatic logic [3:0] sub_exit(cmd_menu_t m);
		case (m)
			MI_ALARM: sub_exit = EXIT_ALARM;
			MI_BRIGHT: sub_exit = EXIT_BRIGHT;
			MI_RADIO: sub_exit = EXIT_RADIO;
			MI_CLOCK: sub_exit = EXIT_CLOCK;
			default: sub_exit = 4'h0;
		endcase
	endfunction : sub_exit
endpackage : cmd_pkg

// ===== hdl/cmd_temp.sv
`timescale 1ns/1ps
module cmd_temp (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// sensor reading in mV and calibration offset in tenths
	input wire logic [9:0] i_mv,
	input wire logic signed [12:0] i_ofs,
	// corrected temperature
	output logic signed [12:0] o_tenths,
	output logic signed [7:0] o_deg
);
	logic signed [12:0] sum;
	logic signed [12:0] mag;
	logic signed [12:0] deg;

	// 10 mV per degree makes one mV one tenth; offset only, no gain
	always_comb begin
		sum = $signed({3'b000, i_mv}) + i_ofs;
		mag = (sum < 0) ? -sum : sum;
		deg = (mag + cmd_pkg::ROUND_HALF) / cmd_pkg::TENTHS;
		if (sum < 0) begin
			deg = -deg;
		end
	end

	// signed, tenths kept, shown value rounded half away from zero
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_tenths <= 13'sh0000;
			o_deg <= 8'sh00;
		end else begin
			o_tenths <= sum;
			o_deg <= deg[7:0];
		end
	end
endmodule : cmd_temp

// ===== verif/cmd_keypad_model.sv
`timescale 1ns/1ps
module cmd_keypad_model (
	// clock
	input wire logic i_clk,
	// key pins, low while pressed
	output logic [3:0] o_key_n
);
	initial o_key_n = 4'hF;
	// one key at a time; a released pin sits at its pull-up level
	task automatic press(input int k, input int hold);
		@(posedge i_clk);
		o_key_n[k] <= 1'b0;
		@(posedge i_clk);
		o_key_n[k] <= 1'b1; // bounce to be ignored
		@(posedge i_clk);
		o_key_n[k] <= 1'b0;
		repeat (hold) @(posedge i_clk);
		o_key_n[k] <= 1'b1;
		repeat (16) @(posedge i_clk);
	endtask : press
endmodule : cmd_keypad_model

// ===== verif/cmd_menu_ctrl_assertions.sv
`timescale 1ns/1ps
module cmd_menu_ctrl_assertions #(
	parameter int DEB_CYC = 4
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// inputs watched
	input wire logic [3:0] i_key_n,
	input wire logic i_radio_pin,
	input wire logic i_synced,
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	// outputs watched
	input wire logic [31:0] o_rdata,
	input wire logic [4:0] o_bright,
	input wire logic o_auto_bright_en,
	input wire logic o_alarm_tmp,
	input wire logic o_rx_led
);
	logic rxen_reg;
	logic [7:0] plus_cnt_reg;
	logic [7:0] minus_cnt_reg;
	// shadow of the led enable, since the checker cannot read registers
	always_ff @(posedge i_clk) begin
		if (i_rst)
			rxen_reg <= 1'b1;
		else if (i_wr && i_addr == cmd_pkg::REG_CFG)
			rxen_reg <= i_wdata[0];
	end
	always_ff @(posedge i_clk) begin
		if (i_key_n[2])
			plus_cnt_reg <= 8'h00;
		else if (plus_cnt_reg != 8'hFF)
			plus_cnt_reg <= plus_cnt_reg + 8'h01;
	end
	always_ff @(posedge i_clk) begin
		if (i_key_n[3])
			minus_cnt_reg <= 8'h00;
		else if (minus_cnt_reg != 8'hFF)
			minus_cnt_reg <= minus_cnt_reg + 8'h01;
	end
	////////////////////////////////////////////////////////////////
	chk_reset_vals: assert property (@(posedge i_clk)
		i_rst |=> (o_bright == 5'h00 && o_auto_bright_en && !o_alarm_tmp
		&& !o_rx_led && o_rdata == 32'h0))
		else $error("outputs not at reset values");
	chk_rdata_idle: assert property (@(posedge i_clk) disable iff (i_rst)
		!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data not zero outside read answer");
	chk_led_high: assert property (@(posedge i_clk) disable iff (i_rst)
		(!i_synced && rxen_reg && i_radio_pin) [*6] |-> o_rx_led)
		else $error("receive led not following high signal");
	chk_led_low: assert property (@(posedge i_clk) disable iff (i_rst)
		(!i_synced && rxen_reg && !i_radio_pin) [*6] |-> !o_rx_led)
		else $error("receive led not following low signal");
	chk_flash_full: assert property (@(posedge i_clk) disable iff (i_rst)
		(!o_auto_bright_en) [*3] |-> o_bright == cmd_pkg::BRIGHT_FULL)
		else $error("flash active without full brightness");
	chk_bright_max: assert property (@(posedge i_clk) disable iff (i_rst)
		o_bright <= cmd_pkg::BRIGHT_FULL)
		else $error("brightness above full scale");
	chk_alarm_deb: assert property (@(posedge i_clk) disable iff (i_rst)
		$changed(o_alarm_tmp) |-> int'(plus_cnt_reg) >= DEB_CYC)
		else $error("alarm toggled without debounced plus");
	chk_flash_deb: assert property (@(posedge i_clk) disable iff (i_rst)
		$changed(o_auto_bright_en) |-> int'(minus_cnt_reg) >= DEB_CYC)
		else $error("flash toggled without debounced minus");
endmodule : cmd_menu_ctrl_assertions
bind cmd_menu_ctrl cmd_menu_ctrl_assertions #(.DEB_CYC(DEB_CYC)) u_chk (
	.i_clk(i_clk), .i_rst(i_rst), .i_key_n(i_key_n),
	.i_radio_pin(i_radio_pin), .i_synced(i_synced), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.o_bright(o_bright), .o_auto_bright_en(o_auto_bright_en),
	.o_alarm_tmp(o_alarm_tmp), .o_rx_led(o_rx_led));

// ===== verif/cmd_menu_ctrl_tb.sv
`timescale 1ns/1ps
module cmd_menu_ctrl_tb;
	logic i_clk;
	logic i_rst;
	logic [3:0] key_n;
	logic [9:0] temp_mv;
	logic radio;
	logic syncing;
	logic synced;
	logic present;
	cmd_pkg::cmd_sync_t stage;
	logic [31:0] exp_v;
	int ed;
	logic [4:0] norm_br;
	logic [3:0] addr;
	logic [31:0] wdata;
	logic wr_s;
	logic rd_s;
	logic [31:0] rdata;
	cmd_pkg::cmd_disp_t disp;
	logic [4:0] bright;
	logic auto_en;
	logic alarm;
	logic rx_led;
	logic [31:0] lfsr;
	logic [31:0] d;
	int fail_count;
	int num_checks;
	cmd_keypad_model kp (.i_clk(i_clk), .o_key_n(key_n));
	cmd_menu_ctrl #(.DEB_CYC(4), .LONG_CYC(40), .IDLE_CYC(60), .ALT_CYC(50)) dut (
		.i_clk(i_clk), .i_rst(i_rst), .i_key_n(key_n), .i_temp_mv(temp_mv),
		.i_temp_present(present), .i_radio_pin(radio), .i_syncing(syncing),
		.i_synced(synced), .i_sync_stage(stage),
		.i_time_bcd(16'h1234), .i_date_bcd(16'h0107), .i_norm_bright(norm_br),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s),
		.o_rdata(rdata), .o_disp(disp), .o_bright(bright),
		.o_auto_bright_en(auto_en), .o_alarm_tmp(alarm), .o_rx_led(rx_led));
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lf(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lf
	// rounding half away from zero, one tenth per mV
	function automatic int exp_deg(input int mv, input int o);
		int t;
		t = mv + o;
		return (t < 0) ? (t - 5) / 10 : (t + 5) / 10;
	endfunction : exp_deg
	task automatic wrap_up();
		$display("checks %0d failures %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", w, e, s);
		end
	endtask : chk
	task automatic rd(input logic [3:0] a);
		@(posedge i_clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge i_clk);
		rd_s <= 1'b0;
		// answer stands for this cycle only; take it mid-cycle
		@(negedge i_clk);
		d = rdata;
		@(posedge i_clk);
	endtask : rd
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge i_clk);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge i_clk);
		wr_s <= 1'b0;
	endtask : wr
	task automatic st(input string w, input int lsb, input int wd, input int e);
		rd(cmd_pkg::REG_STATUS);
		chk(w, (d >> lsb) & ((32'h1 << wd) - 32'h1), 32'(e));
	endtask : st
	// bounded wait for the calibration edit to close by itself
	task automatic idle();
		int n;
		n = 0;
		do begin
			rd(cmd_pkg::REG_STATUS);
			n++;
		end while (d[15:14] !== 2'b00 && n < 200);
		if (d[15:14] !== 2'b00) begin
			fail_count++;
			wrap_up();
		end
	endtask : idle
	////////////////////////////////////////////////////////////////
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	// slow random receiver signal, so the led has time to follow it
	always @(posedge i_clk) begin
		if (i_rst) begin
			lfsr <= 32'hF692B8A3;
			radio <= 1'b0;
		end else begin
			lfsr <= lf(lfsr);
			if (lfsr[3:0] == 4'h0)
				radio <= lfsr[9];
		end
	end
	initial begin
		repeat (100000) @(posedge i_clk);
		fail_count++;
		wrap_up();
	end
	initial begin
		{i_rst, syncing, wr_s, rd_s} = 4'h8;
		{synced, present} = 2'b01;
		stage = cmd_pkg::SY_NOSIG;
		{temp_mv, addr, wdata} = '0;
		norm_br = 5'h0C;
		fail_count = 0;
		num_checks = 0;
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		rd(cmd_pkg::REG_CFG);
		chk("cfg reset", d, 32'h00000A01);
		wr(4'hC, 32'hFFFFFFFF);
		wr(cmd_pkg::REG_STATUS, 32'hFFFFFFFF);
		rd(4'hC);
		chk("unmapped", d, 32'h0);
		st("status reset", 0, 16, 16'h0200);
		kp.press(2, 12);
		chk("alarm on", 32'(alarm), 32'h1);
		kp.press(2, 12);
		chk("alarm off", 32'(alarm), 32'h0);
		kp.press(3, 12);
		chk("flash", {auto_en, bright}, 32'h19);
		kp.press(3, 12);
		chk("flash off", 32'(auto_en), 32'h1);
		kp.press(0, 12);
		st("item", 0, 4, 1);
		for (int m = 0; m < 4; m++) begin
			kp.press(2, 12);
			st("mode up", 9, 2, (m + 2) % 4);
		end
		kp.press(3, 12);
		st("mode down", 9, 2, 0);
		kp.press(0, 12);
		st("item", 0, 4, 2);
		kp.press(2, 12);
		st("temp on", 11, 1, 1);
		kp.press(3, 12);
		st("temp off", 11, 1, 0);
		temp_mv <= 10'd253;
		kp.press(3, 60);
		st("ofs edit", 14, 2, 2);
		kp.press(2, 12);
		kp.press(2, 12);
		idle();
		rd(cmd_pkg::REG_TEMP);
		chk("offset", d[28:16], 32'h2);
		kp.press(2, 60);
		st("ref edit", 14, 2, 1);
		kp.press(2, 12);
		idle();
		rd(cmd_pkg::REG_TEMP);
		chk("ref offset", d[28:16], 32'h3);
		for (int i = 0; i < 6; i++) begin
			temp_mv <= 10'(lfsr % 900);
			repeat (4) @(posedge i_clk);
			rd(cmd_pkg::REG_TEMP);
			chk("degrees", d[7:0], 8'(exp_deg(int'(temp_mv), 3)));
		end
		kp.press(0, 12);
		kp.press(2, 12);
		st("in sub", 8, 1, 1);
		for (int s = 1; s <= 13; s++) begin
			kp.press(0, 12);
			st("sub idx", 4, 4, s % 7);
		end
		kp.press(2, 12);
		st("left sub", 8, 1, 0);
		for (int m = 4; m <= 9; m++) begin
			kp.press(0, 12);
			st("item", 0, 4, m);
		end
		for (int m = 8; m >= 0; m--) begin
			kp.press(1, 12);
			st("item", 0, 4, m);
		end
		st("mode kept", 9, 2, 0);
		chk("dashes", 32'(disp.sym), 32'({4{cmd_pkg::SYM_DASH}}));
		// enable the temperature, then back to normal: shown alone
		kp.press(0, 12);
		kp.press(0, 12);
		kp.press(2, 12);
		kp.press(1, 12);
		kp.press(1, 12);
		ed = exp_deg(int'(temp_mv), 3);
		exp_v = 32'({cmd_pkg::SYM_BLANK, 5'(ed / 10), 5'(ed % 10),
			cmd_pkg::SYM_DEG});
		chk("temp shown", 32'(disp.sym), exp_v);
		present <= 1'b0;
		repeat (4) @(posedge i_clk);
		chk("no sensor", 32'(disp.sym), 32'({4{cmd_pkg::SYM_DASH}}));
		wr(cmd_pkg::REG_CFG, 32'h00000001);
		syncing <= 1'b1;
		repeat (4) @(posedge i_clk);
		chk("blank", 32'(disp.sym), 32'({4{cmd_pkg::SYM_BLANK}}));
		chk("dot", 32'(disp.dp), 32'h1);
		wr(cmd_pkg::REG_CFG, 32'h00000501);
		repeat (4) @(posedge i_clk);
		chk("rx bright", 32'(bright), 32'h5);
		stage <= cmd_pkg::SY_SEARCH;
		repeat (4) @(posedge i_clk);
		exp_v = 32'({cmd_pkg::SYM_S, cmd_pkg::SYM_E, cmd_pkg::SYM_R,
			cmd_pkg::SYM_C});
		chk("search text", 32'(disp.sym), exp_v);
		stage <= cmd_pkg::SY_READ;
		repeat (4) @(posedge i_clk);
		exp_v = 32'({cmd_pkg::SYM_R, cmd_pkg::SYM_D, 5'h06, 5'h00});
		chk("read text", 32'(disp.sym), exp_v);
		synced <= 1'b1;
		repeat (4) @(posedge i_clk);
		chk("led synced", 32'(rx_led), 32'h0);
		repeat (300) @(posedge i_clk);
		wrap_up();
	end
endmodule : cmd_menu_ctrl_tb
